// >>> design/tcu_timer.sv
`timescale 1ns/1ps
`include "tcu_defines.svh"
module tcu_timer (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire tcu_pkg::tcu_wb_req_type wb_req_i,
   output tcu_pkg::tcu_wb_rsp_type      wb_rsp_o,
   input  wire logic                    osc_in_pin_i,
   output logic                         compare_output_o,
   output logic                         irq_compare_o,
   output logic                         irq_overflow_o
);
   import tcu_pkg::*;

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [2:0]  clock_select_field_q;
   tcu_wgm_type waveform_mode_field_q;
   logic [1:0]  compare_output_action_q;
   logic        async_clock_select_q;
   logic [7:0]  timer_count_q;
   logic [7:0]  compare_value_q;
   logic [7:0]  compare_buffer_q;
   logic        overflow_flag_q;
   logic        compare_match_flag_q;
   logic        overflow_irq_enable_q;
   logic        compare_irq_enable_q;
   logic        block_q;
   logic        down_q;
   logic        compare_output_q;
   logic        match_pend_q;

   logic [31:0] rd_data;
   logic        wr;
   logic        rd;
   logic [7:0]  wdat;
   logic        timer_tick;
   logic        wr_ctrl;
   logic        wr_count;
   logic        wr_cmp;
   logic        wr_flag;
   logic        wr_mask;
   logic        wr_async;
   logic        wr_service;
   logic        pwm;
   logic        buffered;
   logic        at_top;
   logic        at_bottom;
   logic        match;
   logic        force_cmp;
   logic [7:0]  count_d;
   logic        down_d;
   logic        ovf_set;

   assign wdat = wb_req_i.dat[7:0];

   tcu_wb_regs u_regs (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .req_i     (wb_req_i),
      .rsp_o     (wb_rsp_o),
      .rd_data_i (rd_data),
      .wr_o      (wr),
      .rd_o      (rd)
   );

   tcu_tick_gen u_tick (
      .clk_i                (clk_i),
      .rst_i                (rst_i),
      .clock_select_field_i (clock_select_field_q),
      .async_clock_select_i (async_clock_select_q),
      .osc_in_pin_i         (osc_in_pin_i),
      .timer_tick_o         (timer_tick)
   );

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   assign wr_ctrl    = wr & (wb_req_i.adr == `TCU_ADDR_CTRL);
   assign wr_count   = wr & (wb_req_i.adr == `TCU_ADDR_COUNT);
   assign wr_cmp     = wr & (wb_req_i.adr == `TCU_ADDR_CMP);
   assign wr_flag    = wr & (wb_req_i.adr == `TCU_ADDR_FLAG);
   assign wr_mask    = wr & (wb_req_i.adr == `TCU_ADDR_MASK);
   assign wr_async   = wr & (wb_req_i.adr == `TCU_ADDR_ASYNC);
   assign wr_service = wr & (wb_req_i.adr == `TCU_ADDR_SERVICE);

   // ----------------------------------------------------------------
   // mode decode and counter status
   // ----------------------------------------------------------------
   assign pwm       = (waveform_mode_field_q == WGM_PHASE_PWM) | (waveform_mode_field_q == WGM_FAST_PWM);
   assign buffered  = pwm;
   assign at_bottom = (timer_count_q == `TCU_BOTTOM);
   assign at_top    = (timer_count_q == `TCU_MAX);
   assign match     = (timer_count_q == compare_value_q);
   assign force_cmp = wr_ctrl & wdat[`TCU_CTRL_FOC_BIT] & ~pwm;

   // ----------------------------------------------------------------
   // counting sequence
   // ----------------------------------------------------------------
   always_comb begin
      count_d = timer_count_q;
      down_d  = down_q;
      ovf_set = 1'b0;
      unique case (waveform_mode_field_q)
         WGM_NORMAL: begin
            count_d = timer_count_q + 8'h01;
            ovf_set = at_top;
         end
         WGM_CTC: begin
            // top is the compare value here
            count_d = match ? `TCU_BOTTOM : timer_count_q + 8'h01;
            ovf_set = at_top;
         end
         WGM_FAST_PWM: begin
            count_d = at_top ? `TCU_BOTTOM : timer_count_q + 8'h01;
            ovf_set = at_top;
         end
         WGM_PHASE_PWM: begin
            if (down_q) begin
               count_d = timer_count_q - 8'h01;
               if (timer_count_q == 8'h01) begin
                  down_d = 1'b0;
               end
               // flag in the tick that brings the count to bottom
               ovf_set = (timer_count_q == 8'h01);
            end else begin
               count_d = timer_count_q + 8'h01;
               if (timer_count_q == 8'hfe) begin
                  down_d = 1'b1;
               end
            end
            if (at_top) begin
               count_d = 8'hfe;
               down_d  = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_count_q <= `TCU_RESET_BYTE;
      end else if (wr_count) begin
         timer_count_q <= wdat;
      end else if (timer_tick) begin
         timer_count_q <= count_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         down_q <= 1'b0;
      end else if (waveform_mode_field_q != WGM_PHASE_PWM) begin
         down_q <= 1'b0;
      end else if (timer_tick & ~wr_count) begin
         down_q <= down_d;
      end
   end

   // ----------------------------------------------------------------
   // match blocking and flag timing
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         block_q <= 1'b0;
      end else if (wr_count) begin
         block_q <= 1'b1;
      end else if (timer_tick) begin
         block_q <= 1'b0;
      end
   end

   // a match seen on one tick sets the flag on the next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         match_pend_q <= 1'b0;
      end else if (timer_tick) begin
         match_pend_q <= match & ~block_q & ~wr_count;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clock_select_field_q    <= 3'h0;
         waveform_mode_field_q   <= WGM_NORMAL;
         compare_output_action_q <= 2'h0;
      end else if (wr_ctrl) begin
         clock_select_field_q    <= wdat[`TCU_CTRL_CS_LSB +: 3];
         waveform_mode_field_q   <= tcu_wgm_type'(wdat[`TCU_CTRL_WGM_LSB +: 2]);
         compare_output_action_q <= wdat[`TCU_CTRL_COM_LSB +: 2];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         async_clock_select_q <= 1'b0;
      end else if (wr_async) begin
         async_clock_select_q <= wdat[`TCU_ASYNC_AS_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overflow_irq_enable_q <= 1'b0;
         compare_irq_enable_q  <= 1'b0;
      end else if (wr_mask) begin
         overflow_irq_enable_q <= wdat[`TCU_FLAG_OVF_BIT];
         compare_irq_enable_q  <= wdat[`TCU_FLAG_CMP_BIT];
      end
   end

   // ----------------------------------------------------------------
   // compare value and buffer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_buffer_q <= `TCU_RESET_BYTE;
      end else if (wr_cmp) begin
         compare_buffer_q <= wdat;
      end
   end

   // fast pwm and phase pwm both load at max
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_value_q <= `TCU_RESET_BYTE;
      end else if (~buffered) begin
         if (wr_cmp) begin
            compare_value_q <= wdat;
         end
      end else if (timer_tick & ~wr_count) begin
         if ((waveform_mode_field_q == WGM_FAST_PWM) ? at_top : at_top) begin
            compare_value_q <= compare_buffer_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // flags; hardware set wins over software clear
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overflow_flag_q <= 1'b0;
      end else if (timer_tick & ~wr_count & ovf_set) begin
         overflow_flag_q <= 1'b1;
      end else if ((wr_flag | wr_service) & wdat[`TCU_FLAG_OVF_BIT]) begin
         overflow_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_match_flag_q <= 1'b0;
      end else if (timer_tick & match_pend_q) begin
         compare_match_flag_q <= 1'b1;
      end else if ((wr_flag | wr_service) & wdat[`TCU_FLAG_CMP_BIT]) begin
         compare_match_flag_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // compare output waveform
   // ----------------------------------------------------------------
   // state is never reset on a mode change, only by the action field
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_output_q <= 1'b0;
      end else if (force_cmp) begin
         // action written together with the strobe applies at once
         unique case (wdat[`TCU_CTRL_COM_LSB +: 2])
            2'h1:    compare_output_q <= ~compare_output_q;
            2'h2:    compare_output_q <= 1'b0;
            2'h3:    compare_output_q <= 1'b1;
            default: compare_output_q <= compare_output_q;
         endcase
      end else if (timer_tick & ~wr_count) begin
         if (~pwm & match & ~block_q) begin
            unique case (compare_output_action_q)
               2'h1:    compare_output_q <= ~compare_output_q;
               2'h2:    compare_output_q <= 1'b0;
               2'h3:    compare_output_q <= 1'b1;
               default: compare_output_q <= compare_output_q;
            endcase
         end else if (pwm & compare_output_action_q[1]) begin
            if (match & ~block_q) begin
               compare_output_q <= (waveform_mode_field_q == WGM_FAST_PWM) ?
                                   compare_output_action_q[0] : (compare_output_action_q[0] ^ down_q);
            end else if ((waveform_mode_field_q == WGM_FAST_PWM) & at_top) begin
               compare_output_q <= ~compare_output_action_q[0];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // read mux and outputs
   // ----------------------------------------------------------------
   always_comb begin
      rd_data = 32'h0000_0000;
      unique case (wb_req_i.adr)
         `TCU_ADDR_CTRL:  rd_data[7:0] = {1'b0, compare_output_action_q, waveform_mode_field_q,
                                          clock_select_field_q};
         `TCU_ADDR_COUNT: rd_data[7:0] = timer_count_q;
         `TCU_ADDR_CMP:   rd_data[7:0] = buffered ? compare_buffer_q : compare_value_q;
         `TCU_ADDR_FLAG:  rd_data[1:0] = {compare_match_flag_q, overflow_flag_q};
         `TCU_ADDR_MASK:  rd_data[1:0] = {compare_irq_enable_q, overflow_irq_enable_q};
         `TCU_ADDR_ASYNC: rd_data[0]   = async_clock_select_q;
         default:         rd_data      = 32'h0000_0000;
      endcase
   end

   assign compare_output_o = compare_output_q;
   assign irq_compare_o    = compare_match_flag_q & compare_irq_enable_q;
   assign irq_overflow_o   = overflow_flag_q & overflow_irq_enable_q;
endmodule : tcu_timer

// >>> design/tcu_defines.svh
`ifndef TCU_DEFINES_SVH
`define TCU_DEFINES_SVH
// Functional notes
// - count zero is bottom, all ones is max.
// - top is max or the compare value, chosen by waveform mode.
// - tick from prescaled bus clock, or oscillator input when async select set.
// - clock select zero stops the counter entirely.
// - software may read and write the count at any time.
// - software count write beats clear, increment and decrement.
// - each tick clears, increments or decrements per waveform mode.
// - overflow flag set per mode and may raise an interrupt.
// - comparator runs continuously; match flag set on the following tick.
// - compare flag interrupts when enabled; cleared by service or write-one.
// - compare value double buffered in pwm modes only.
// - buffered compare value loads only at top or bottom; the code loads it at max in both pwm modes.
// - compare writes reach buffer when buffered, working register otherwise.
// - force strobe in non-pwm modes acts on output only.
// - count write blocks compare match on the next tick, even stopped.
// - compare output keeps its state across mode changes.
// - compare output action is not buffered, applies immediately.
// - all requests visible in flag register, each maskable.
// - count and compare value are eight bits.
// - counter unit raises top at max and bottom at zero.
// - mode 0 counts up, wraps, overflow set as count becomes zero.
// - mode 2 clears on compare match; mode 3 single-slope to max.

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TCU_ADDR_CTRL    8'h00
`define TCU_ADDR_COUNT   8'h04
`define TCU_ADDR_CMP     8'h08
`define TCU_ADDR_FLAG    8'h0c
`define TCU_ADDR_MASK    8'h10
`define TCU_ADDR_ASYNC   8'h14
`define TCU_ADDR_SERVICE 8'h18

// ----------------------------------------------------------------
// control, flag and async register fields
// ----------------------------------------------------------------
`define TCU_CTRL_CS_LSB  0
`define TCU_CTRL_WGM_LSB 3
`define TCU_CTRL_COM_LSB 5
`define TCU_CTRL_FOC_BIT 7
`define TCU_FLAG_OVF_BIT 0
`define TCU_FLAG_CMP_BIT 1
`define TCU_ASYNC_AS_BIT 0

`define TCU_BOTTOM       8'h00
`define TCU_MAX          8'hff
`define TCU_RESET_BYTE   8'h00
`endif

// >>> design/tcu_pkg.sv
package tcu_pkg;
   typedef enum logic [1:0] {
      WGM_NORMAL,
      WGM_PHASE_PWM,
      WGM_CTC,
      WGM_FAST_PWM
   } tcu_wgm_type;

   typedef struct packed {
      logic [7:0] adr;
      logic       we;
      logic [3:0] sel;
      logic [31:0] dat;
      logic       cyc;
      logic       stb;
   } tcu_wb_req_type;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } tcu_wb_rsp_type;
endpackage : tcu_pkg

// >>> design/tcu_tick_gen.sv
`timescale 1ns/1ps
`include "tcu_defines.svh"
module tcu_tick_gen (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [2:0] clock_select_field_i,
   input  wire logic       async_clock_select_i,
   input  wire logic       osc_in_pin_i,
   output logic            timer_tick_o
);
   import tcu_pkg::*;
   logic [9:0] pre_q;
   logic       osc_q;
   logic       tap;
   logic       int_tick;
   logic       osc_rise;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_q <= 10'h000;
      end else if (int_tick) begin
         // in async mode the prescaler counts oscillator edges, not bus clocks
         pre_q <= pre_q + 10'h001;
      end
   end

   // oscillator input already synchronous; edge sampled once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_q <= 1'b0;
      end else begin
         osc_q <= osc_in_pin_i;
      end
   end
   assign osc_rise = osc_in_pin_i & ~osc_q;

   always_comb begin
      unique case (clock_select_field_i)
         3'h1:    tap = 1'b1;
         3'h2:    tap = (pre_q[2:0] == 3'h7);
         3'h3:    tap = (pre_q[4:0] == 5'h1f);
         3'h4:    tap = (pre_q[5:0] == 6'h3f);
         3'h5:    tap = (pre_q[6:0] == 7'h7f);
         3'h6:    tap = (pre_q[7:0] == 8'hff);
         3'h7:    tap = (pre_q == 10'h3ff);
         default: tap = 1'b0;
      endcase
   end

   // prescaler acts on oscillator edges in async mode
   assign int_tick = async_clock_select_i ? osc_rise : 1'b1;
   assign timer_tick_o = int_tick & tap & (clock_select_field_i != 3'h0);
endmodule : tcu_tick_gen

// >>> design/tcu_wb_regs.sv
`timescale 1ns/1ps
`include "tcu_defines.svh"
module tcu_wb_regs (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire tcu_pkg::tcu_wb_req_type req_i,
   output tcu_pkg::tcu_wb_rsp_type rsp_o,
   input  wire logic [31:0]        rd_data_i,
   output logic                    wr_o,
   output logic                    rd_o
);
   import tcu_pkg::*;
   logic ack_q;
   logic req;
   assign req = req_i.cyc & req_i.stb & ~ack_q;
   assign wr_o = req & req_i.we & req_i.sel[0];
   assign rd_o = req & ~req_i.we;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rsp_o.dat <= 32'h0000_0000;
      end else if (rd_o) begin
         rsp_o.dat <= rd_data_i;
      end
   end
   assign rsp_o.ack = ack_q;
endmodule : tcu_wb_regs

// >>> tb/tcu_timer_sva.sv
`timescale 1ns/1ps
`include "tcu_defines.svh"
module tcu_timer_sva (
   input wire logic                    clk_i,
   input wire logic                    rst_i,
   input wire tcu_pkg::tcu_wb_req_type wb_req_i,
   input wire tcu_pkg::tcu_wb_rsp_type wb_rsp_o,
   input wire logic                    osc_in_pin_i,
   input wire logic                    compare_output_o,
   input wire logic                    irq_compare_o,
   input wire logic                    irq_overflow_o
);
   import tcu_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------------------------------
   // shadow of bus-written state
   // ----------------------------------------------------------------
   logic       taken;
   logic       rd;
   logic       wr;
   logic [7:0] a;
   logic [7:0] d;
   logic [2:0] cs_q;
   logic       pwm_q;
   logic       cmp_en_q;
   logic       ovf_en_q;
   logic       cnt_ok_q;
   logic [7:0] cnt_q;
   assign taken = wb_req_i.cyc & wb_req_i.stb & ~wb_rsp_o.ack;
   assign rd    = taken & ~wb_req_i.we;
   assign wr    = taken & wb_req_i.we & wb_req_i.sel[0];
   assign a     = wb_req_i.adr;
   assign d     = wb_req_i.dat[7:0];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cs_q     <= 3'h0;
         pwm_q    <= 1'b0;
         cmp_en_q <= 1'b0;
         ovf_en_q <= 1'b0;
      end else if (wr && a == `TCU_ADDR_CTRL) begin
         cs_q  <= d[2:0];
         pwm_q <= d[3];
      end else if (wr && a == `TCU_ADDR_MASK) begin
         cmp_en_q <= d[1];
         ovf_en_q <= d[0];
      end
   end
   // count is only predictable when written while stopped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_ok_q <= 1'b0;
         cnt_q    <= 8'h00;
      end else if (wr && a == `TCU_ADDR_CTRL && d[2:0] != 3'h0) begin
         cnt_ok_q <= 1'b0;
      end else if (wr && a == `TCU_ADDR_COUNT && cs_q == 3'h0) begin
         cnt_ok_q <= 1'b1;
         cnt_q    <= d;
      end
   end
   a_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (taken |=> wb_rsp_o.ack)
      else $error("request not answered");
   a_upper_zero: assert property (wb_rsp_o.ack |-> wb_rsp_o.dat[31:8] == 24'h0)
      else $error("upper read bits set");
   a_unmapped_zero: assert property (rd && a > `TCU_ADDR_SERVICE |=> wb_rsp_o.dat == 32'h0)
      else $error("unmapped read not zero");
   a_irq_cmp_mask: assert property (irq_compare_o |-> cmp_en_q)
      else $error("compare irq while masked");
   a_irq_ovf_mask: assert property (irq_overflow_o |-> ovf_en_q)
      else $error("overflow irq while masked");
   a_ovf_w1c: assert property (wr && a == `TCU_ADDR_FLAG && d[0] && cs_q == 3'h0 |=> !irq_overflow_o)
      else $error("overflow flag not cleared");
   a_cmp_service: assert property (wr && a == `TCU_ADDR_SERVICE && d[1] && cs_q == 3'h0 |=> !irq_compare_o)
      else $error("compare flag not cleared by service");
   a_count_hold: assert property (rd && a == `TCU_ADDR_COUNT && cnt_ok_q |=> wb_rsp_o.dat[7:0] == cnt_q)
      else $error("stopped count changed");
   a_force_out: assert property (wr && a == `TCU_ADDR_CTRL && d[7] && d[6] && !d[3] && !pwm_q
      |=> compare_output_o == $past(d[5]))
      else $error("force strobe output wrong");
   a_out_keeps: assert property (wr && a == `TCU_ADDR_CTRL && !d[7] && cs_q == 3'h0 && d[2:0] == 3'h0
      |=> $stable(compare_output_o))
      else $error("output changed on mode write");
endmodule : tcu_timer_sva

bind tcu_timer tcu_timer_sva tcu_timer_sva_inst (
   .clk_i            (clk_i),
   .rst_i            (rst_i),
   .wb_req_i         (wb_req_i),
   .wb_rsp_o         (wb_rsp_o),
   .osc_in_pin_i     (osc_in_pin_i),
   .compare_output_o (compare_output_o),
   .irq_compare_o    (irq_compare_o),
   .irq_overflow_o   (irq_overflow_o)
);

// >>> tb/tcu_timer_test.sv
`timescale 1ns/1ps
`include "tcu_defines.svh"
module tcu_timer_test;
   import tcu_pkg::*;
   logic           clk_i;
   logic           rst_i;
   logic           osc_in_pin_i;
   logic           compare_output_o;
   logic           irq_compare_o;
   logic           irq_overflow_o;
   tcu_wb_req_type wb_req;
   tcu_wb_rsp_type wb_rsp;
   logic [31:0]    rdat;
   int             num_errors;
   int             comparisons;
   int             i;
   int             k;
   logic [7:0]     regs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
   logic [1:0]     acts [3] = '{2'h3, 2'h2, 2'h1};
   logic           outs [3] = '{1'b1, 1'b0, 1'b1};
   tcu_timer tcu_timer_inst (
      .clk_i            (clk_i),
      .rst_i            (rst_i),
      .wb_req_i         (wb_req),
      .wb_rsp_o         (wb_rsp),
      .osc_in_pin_i     (osc_in_pin_i),
      .compare_output_o (compare_output_o),
      .irq_compare_o    (irq_compare_o),
      .irq_overflow_o   (irq_overflow_o)
   );
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // ----------------------------------------------------------------
   // bus and report tasks
   // ----------------------------------------------------------------
   task final_report;
      $display("mismatches %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task bus(input logic we, input logic [7:0] adr, input logic [7:0] wd);
      int n;
      @(posedge clk_i);
      wb_req <= '{adr: adr, we: we, sel: 4'h1, dat: {24'h0, wd}, cyc: 1'b1, stb: 1'b1};
      for (n = 0; n < 20; n++) begin
         @(negedge clk_i);
         if (wb_rsp.ack === 1'b1) begin
            @(posedge clk_i);
            break;
         end
      end
      rdat = wb_rsp.dat;
      wb_req <= '0;
      if (n == 20) begin
         num_errors++;
         final_report();
      end
   endtask : bus
   task wr(input logic [7:0] adr, input logic [7:0] wd);
      bus(1'b1, adr, wd);
   endtask : wr
   task rdchk(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] msk, input string what);
      bus(1'b0, adr, 8'h00);
      check(what, rdat & msk, exp);
   endtask : rdchk
   task run(input int n);
      repeat (n) @(posedge clk_i);
   endtask : run
   // load compare and count, clear flags, then start with ctrl
   task start(input logic [7:0] cmp, input logic [7:0] cnt, input logic [7:0] ctrl);
      wr(`TCU_ADDR_CMP, cmp);
      wr(`TCU_ADDR_COUNT, cnt);
      wr(`TCU_ADDR_FLAG, 8'h03);
      wr(`TCU_ADDR_CTRL, ctrl);
   endtask : start
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      wb_req = '0;
      osc_in_pin_i = 1'b0;
      rst_i = 1'b1;
      num_errors = 0;
      comparisons = 0;
      run(16);
      rst_i <= 1'b0;
      foreach (regs[j]) rdchk(regs[j], 32'h0, 32'hffffffff, "reset value");
      wr(8'h1c, 8'ha5);
      rdchk(8'h1c, 32'h0, 32'hffffffff, "unmapped");
      wr(`TCU_ADDR_COUNT, 8'h5a);
      run(20);
      rdchk(`TCU_ADDR_COUNT, 32'h5a, 32'hff, "stopped count");
      $display("test reset done");
      wr(`TCU_ADDR_MASK, 8'h01);
      start(8'h80, 8'hfd, 8'h01);
      for (k = 0; k < 40 && irq_overflow_o !== 1'b1; k++) @(posedge clk_i);
      check("overflow irq", irq_overflow_o, 1'b1);
      if (k == 40) final_report();
      wr(`TCU_ADDR_CTRL, 8'h00);
      rdchk(`TCU_ADDR_FLAG, 32'h1, 32'h1, "overflow flag");
      rdchk(`TCU_ADDR_COUNT, 32'h0, 32'hf0, "wrapped count");
      wr(`TCU_ADDR_FLAG, 8'h01);
      check("overflow irq off", irq_overflow_o, 1'b0);
      $display("test overflow done");
      wr(`TCU_ADDR_MASK, 8'h00);
      start(8'h10, 8'h00, 8'h01);
      run(30);
      wr(`TCU_ADDR_CTRL, 8'h00);
      rdchk(`TCU_ADDR_FLAG, 32'h2, 32'h2, "compare flag");
      check("masked irq", irq_compare_o, 1'b0);
      wr(`TCU_ADDR_MASK, 8'h02);
      check("compare irq", irq_compare_o, 1'b1);
      wr(`TCU_ADDR_SERVICE, 8'h02);
      check("serviced irq", irq_compare_o, 1'b0);
      rdchk(`TCU_ADDR_FLAG, 32'h0, 32'h2, "serviced flag");
      $display("test compare done");
      for (i = 0; i < 2; i++) begin
         start(8'h20, i ? 8'h1e : 8'h20, 8'h01);
         run(20);
         wr(`TCU_ADDR_CTRL, 8'h00);
         rdchk(`TCU_ADDR_FLAG, i ? 32'h2 : 32'h0, 32'h2, "blocked match");
      end
      $display("test blocking done");
      start(8'h05, 8'h00, 8'h11);
      run(40);
      wr(`TCU_ADDR_CTRL, 8'h00);
      bus(1'b0, `TCU_ADDR_COUNT, 8'h00);
      check("clear on match", rdat[7:0] <= 8'h05, 1'b1);
      rdchk(`TCU_ADDR_FLAG, 32'h2, 32'h3, "ctc flags");
      start(8'h05, 8'hfe, 8'h09);
      run(8);
      wr(`TCU_ADDR_CTRL, 8'h08);
      bus(1'b0, `TCU_ADDR_COUNT, 8'h00);
      check("down count", rdat[7:0] >= 8'hf0 && rdat[7:0] < 8'hfe, 1'b1);
      $display("test modes done");
      wr(`TCU_ADDR_CTRL, 8'h18);
      start(8'hf0, 8'h00, 8'h19);
      run(30);
      wr(`TCU_ADDR_CTRL, 8'h18);
      rdchk(`TCU_ADDR_FLAG, 32'h2, 32'h2, "buffered compare");
      wr(`TCU_ADDR_FLAG, 8'h03);
      wr(`TCU_ADDR_CTRL, 8'h19);
      run(260);
      wr(`TCU_ADDR_CTRL, 8'h18);
      rdchk(`TCU_ADDR_FLAG, 32'h1, 32'h3, "load at max");
      wr(`TCU_ADDR_CTRL, 8'h00);
      start(8'h08, 8'h00, 8'h01);
      run(30);
      wr(`TCU_ADDR_CTRL, 8'h00);
      rdchk(`TCU_ADDR_FLAG, 32'h2, 32'h2, "direct compare");
      $display("test buffering done");
      start(8'h80, 8'h33, 8'h00);
      foreach (acts[j]) begin
         wr(`TCU_ADDR_CTRL, {1'b0, acts[j], 5'h00});
         wr(`TCU_ADDR_CTRL, {1'b1, acts[j], 5'h00});
         check("forced output", compare_output_o, outs[j]);
      end
      rdchk(`TCU_ADDR_FLAG, 32'h0, 32'h2, "forced flag");
      rdchk(`TCU_ADDR_COUNT, 32'h33, 32'hff, "forced count");
      wr(`TCU_ADDR_CTRL, 8'h38);
      check("output kept", compare_output_o, 1'b1);
      $display("test force done");
      wr(`TCU_ADDR_CTRL, 8'h00);
      wr(`TCU_ADDR_ASYNC, 8'h01);
      start(8'h80, 8'h00, 8'h01);
      run(10);
      repeat (10) begin
         osc_in_pin_i <= 1'b1;
         run(3);
         osc_in_pin_i <= 1'b0;
         run(3);
      end
      run(6);
      wr(`TCU_ADDR_CTRL, 8'h00);
      rdchk(`TCU_ADDR_COUNT, 32'h0a, 32'hff, "oscillator ticks");
      wr(`TCU_ADDR_ASYNC, 8'h00);
      $display("test async done");
      final_report();
   end
endmodule : tcu_timer_test
